/* logic/arith_branch_opcode_decoder.sv */
// Decoder for accumulator add, logical-and, absolute, product-add and branch opcodes.
// Assumes words from the fetch path arrive synchronous to SYS_CLK with a valid strobe,
// and that status flags are stable in the cycle of the first word.
//
// Function
// - Selector 00 pin low, 01 flag set, 10 flag clear, 11 nothing tested.
// - Condition group bits: zero, negative, overflow, carry from msb to lsb.
// - Conditional word: bits 3..0 are mask, bits 7..4 required state.
// - Only conditions with mask bit one take part in the verdict.
// - Mask ANDed with condition values; any set bit means condition met.
// - Absolute value is 1011 1110 0000 0000, one word, one cycle.
// - Add family: shifted direct, high half, short and long immediate forms.
// - Direct add_nosignext_op 0110 0000 carry, 0010 no sign extension, 0011 shift by temp.
// - Auxiliary add immediate is 0111 1000 with 8-bit constant, one cycle.
// - And family: direct, shifted long immediate, immediate shifted by sixteen.
// - Product add is 1011 1110 0000 0100, one word, one cycle.
// - Branch to accumulator is 1011 1110 0010 0000, one word, four cycles.
// - Auxiliary nonzero branch is 0111 1011 plus address word, 2/4/2.
// - Flag branches 1110 0001 and 1110 0010 with zero low byte, plus address.
// - Accumulator branches use 1110 0011 with state and mask low byte.
// - Pin-low branch is 1110 0000 0000 0000 plus address word, 2/4/3.
`timescale 1ns/1ps

module arith_branch_opcode_decoder (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR_WORD,
   input wire logic ACC_ZERO,
   input wire logic ACC_NEG,
   input wire logic OVERFLOW,
   input wire logic CARRY,
   input wire logic TEST_CONTROL_FLAG,
   input wire logic BRANCH_INPUT_PIN,
   input wire logic AUX_NONZERO,
   output logic DECODE_VALID,
   output logic [4:0] OP_CODE,
   output logic UNKNOWN_OP,
   output logic TWO_WORD,
   output logic [3:0] SHIFT_AMOUNT_FIELD,
   output logic [7:0] DIRECT_INDIRECT_ADDR_FIELD,
   output logic [15:0] IMMEDIATE_CONSTANT_FIELD,
   output logic IS_BRANCH,
   output logic BRANCH_TAKEN,
   output logic COND_MET,
   output logic [2:0] CYCLE_COUNT
);

   // ==========================================================
   // Field extraction
   localparam int COND_MASK_MSB = opdec_pkg::COND_STATE_LSB - 1;
   wire [15:0] w = INSTR_WORD;
   wire [3:0] mask = w[COND_MASK_MSB:0];
   wire [3:0] state = w[opdec_pkg::COND_STATE_LSB +: 4];
   wire [1:0] cond_selector_field = w[opdec_pkg::SEL_LSB +: 2];

   // ==========================================================
   // Condition evaluation
   logic [3:0] acc_condition_group;
   always_comb begin
      acc_condition_group = 4'h0;
      acc_condition_group[opdec_pkg::BIT_ZERO] = ACC_ZERO;
      acc_condition_group[opdec_pkg::BIT_NEG] = ACC_NEG;
      acc_condition_group[opdec_pkg::BIT_OVF] = OVERFLOW;
      acc_condition_group[opdec_pkg::BIT_CARRY] = CARRY;
   end

   // A condition value is one when the flag equals its required state.
   // Verdict is any-of: a mask with two bits passes when either matches.
   wire [3:0] cond_value = ~(acc_condition_group ^ state);
   wire [3:0] tested = mask & cond_value;
   wire group_met = |tested;
   wire sel_pin = cond_selector_field == opdec_pkg::SEL_PIN_LOW;
   wire sel_set = cond_selector_field == opdec_pkg::SEL_FLAG_SET;
   wire sel_clr = cond_selector_field == opdec_pkg::SEL_FLAG_CLR;
   wire sel_met = (sel_pin & ~BRANCH_INPUT_PIN) | (sel_set & TEST_CONTROL_FLAG) | (sel_clr & ~TEST_CONTROL_FLAG);
   wire cond_met = sel_met | group_met;

   // ==========================================================
   // Opcode matching
   wire hit_abs = w == opdec_pkg::PAT_ABS;
   wire hit_product_add_op = w == opdec_pkg::PAT_PRODUCT_ADD_OP;
   wire hit_branch_to_acc_op = w == opdec_pkg::PAT_BRANCH_TO_ACC_OP;
   wire hit_and16 = w == opdec_pkg::PAT_AND_16;
   wire hit_add_l = w[15:4] == opdec_pkg::PAT_ADD_IMM_L;
   wire hit_and_sh = w[15:4] == opdec_pkg::PAT_AND_IMM_SH;
   wire hit_add_shift = w[15:12] == opdec_pkg::PAT_ADD_SHIFT;
   wire hit_add_high = w[15:8] == opdec_pkg::PAT_ADD_HIGH;
   wire hit_add_s = w[15:8] == opdec_pkg::PAT_ADD_IMM_S;
   wire hit_add_carry_op = w[15:8] == opdec_pkg::PAT_ADD_CARRY_OP;
   wire hit_add_nosignext_op = w[15:8] == opdec_pkg::PAT_ADD_NOSIGNEXT_OP;
   wire hit_add_treg_shift_op = w[15:8] == opdec_pkg::PAT_ADD_TREG_SHIFT_OP;
   wire hit_aux_add_imm_op = w[15:8] == opdec_pkg::PAT_AUX_ADD_IMM_OP;
   wire hit_and_dir = w[15:8] == opdec_pkg::PAT_AND_DIR;
   wire hit_b = w[15:8] == opdec_pkg::PAT_B;
   wire hit_branch_aux_nonzero_op = w[15:8] == opdec_pkg::PAT_BRANCH_AUX_NONZERO_OP;
   wire cond_branch_op_high = w[15:10] == opdec_pkg::PAT_COND_BRANCH_OP;
   // Selector forms carry no state or mask; a nonzero low byte there is unknown.
   wire cond_branch_op_low_ok = (cond_selector_field == opdec_pkg::SEL_NONE) | (w[7:0] == 8'h00);
   wire hit_cond_branch_op = cond_branch_op_high & cond_branch_op_low_ok;

   // ==========================================================
   // Decode table
   opdec_pkg::op_t op_dec;
   logic two_dec;
   logic branch_dec;
   logic taken_dec;
   logic [2:0] cyc_hi;
   logic [2:0] cyc_lo;
   always_comb begin
      op_dec = opdec_pkg::OP_NONE;
      two_dec = 1'b0;
      branch_dec = 1'b0;
      taken_dec = 1'b0;
      cyc_hi = opdec_pkg::CYC_ONE;
      cyc_lo = opdec_pkg::CYC_ONE;
      if (hit_abs) begin
         op_dec = opdec_pkg::OP_ABS;
      end else if (hit_product_add_op) begin
         op_dec = opdec_pkg::OP_PRODUCT_ADD_OP;
      end else if (hit_branch_to_acc_op) begin
         op_dec = opdec_pkg::OP_BRANCH_TO_ACC_OP;
         branch_dec = 1'b1;
         taken_dec = 1'b1;
         cyc_hi = opdec_pkg::CYC_FOUR;
         cyc_lo = opdec_pkg::CYC_FOUR;
      end else if (hit_and16) begin
         op_dec = opdec_pkg::OP_AND_16;
         two_dec = 1'b1;
         cyc_hi = opdec_pkg::CYC_TWO;
         cyc_lo = opdec_pkg::CYC_TWO;
      end else if (hit_add_l) begin
         op_dec = opdec_pkg::OP_ADD_IMM_L;
         two_dec = 1'b1;
         cyc_hi = opdec_pkg::CYC_TWO;
         cyc_lo = opdec_pkg::CYC_TWO;
      end else if (hit_and_sh) begin
         op_dec = opdec_pkg::OP_AND_IMM_SH;
         two_dec = 1'b1;
         cyc_hi = opdec_pkg::CYC_TWO;
         cyc_lo = opdec_pkg::CYC_TWO;
      end else if (hit_add_shift) begin
         op_dec = opdec_pkg::OP_ADD_SHIFT;
      end else if (hit_add_high) begin
         op_dec = opdec_pkg::OP_ADD_HIGH;
      end else if (hit_add_s) begin
         op_dec = opdec_pkg::OP_ADD_IMM_S;
      end else if (hit_add_carry_op) begin
         op_dec = opdec_pkg::OP_ADD_CARRY_OP;
      end else if (hit_add_nosignext_op) begin
         op_dec = opdec_pkg::OP_ADD_NOSIGNEXT_OP;
      end else if (hit_add_treg_shift_op) begin
         op_dec = opdec_pkg::OP_ADD_TREG_SHIFT_OP;
      end else if (hit_aux_add_imm_op) begin
         op_dec = opdec_pkg::OP_AUX_ADD_IMM_OP;
      end else if (hit_and_dir) begin
         op_dec = opdec_pkg::OP_AND_DIR;
      end else if (hit_b) begin
         op_dec = opdec_pkg::OP_B;
         two_dec = 1'b1;
         branch_dec = 1'b1;
         taken_dec = 1'b1;
         cyc_hi = opdec_pkg::CYC_FOUR;
         cyc_lo = opdec_pkg::CYC_FOUR;
      end else if (hit_branch_aux_nonzero_op) begin
         op_dec = opdec_pkg::OP_BRANCH_AUX_NONZERO_OP;
         two_dec = 1'b1;
         branch_dec = 1'b1;
         taken_dec = AUX_NONZERO;
         cyc_hi = opdec_pkg::CYC_FOUR;
         cyc_lo = opdec_pkg::CYC_TWO;
      end else if (hit_cond_branch_op) begin
         op_dec = opdec_pkg::OP_COND_BRANCH_OP;
         two_dec = 1'b1;
         branch_dec = 1'b1;
         taken_dec = cond_met;
         cyc_hi = opdec_pkg::CYC_FOUR;
         cyc_lo = sel_pin ? opdec_pkg::CYC_THREE : opdec_pkg::CYC_TWO;
      end
   end

   wire [2:0] cyc_dec = taken_dec ? cyc_hi : cyc_lo;
   wire [15:0] imm_dec = {8'h00, w[7:0]};
   wire [3:0] shift_dec = hit_add_shift ? w[11:8] : w[3:0];

   // ==========================================================
   // Sequencer: a two-word op holds its first-word results until the
   // operand or branch address arrives, then reports the whole op at once.
   opdec_pkg::state_t st;
   opdec_pkg::state_t next_st;
   wire take_first = INSTR_VALID & (st == opdec_pkg::ST_FIRST);
   wire take_second = INSTR_VALID & (st == opdec_pkg::ST_SECOND);

   always_comb begin
      case (st)
         opdec_pkg::ST_FIRST: next_st = (INSTR_VALID & two_dec) ? opdec_pkg::ST_SECOND : opdec_pkg::ST_FIRST;
         opdec_pkg::ST_SECOND: next_st = INSTR_VALID ? opdec_pkg::ST_FIRST : opdec_pkg::ST_SECOND;
         default: next_st = opdec_pkg::ST_FIRST;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st <= opdec_pkg::ST_FIRST;
      end else begin
         st <= next_st;
      end
   end

   wire next_valid = (take_first & ~two_dec) | take_second;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         DECODE_VALID <= 1'b0;
      end else begin
         DECODE_VALID <= next_valid;
      end
   end

   // ==========================================================
   // First-word results
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         OP_CODE <= 5'h00;
         UNKNOWN_OP <= 1'b0;
         TWO_WORD <= 1'b0;
         SHIFT_AMOUNT_FIELD <= 4'h0;
         DIRECT_INDIRECT_ADDR_FIELD <= 8'h00;
      end else if (take_first) begin
         OP_CODE <= op_dec;
         UNKNOWN_OP <= op_dec == opdec_pkg::OP_NONE;
         TWO_WORD <= two_dec;
         SHIFT_AMOUNT_FIELD <= shift_dec;
         DIRECT_INDIRECT_ADDR_FIELD <= w[7:0];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         IS_BRANCH <= 1'b0;
         BRANCH_TAKEN <= 1'b0;
         COND_MET <= 1'b0;
         CYCLE_COUNT <= 3'h0;
      end else if (take_first) begin
         IS_BRANCH <= branch_dec;
         BRANCH_TAKEN <= taken_dec;
         COND_MET <= cond_met;
         CYCLE_COUNT <= cyc_dec;
      end
   end

   // ==========================================================
   // Operand word: second word of a pair, or the short constant.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         IMMEDIATE_CONSTANT_FIELD <= 16'h0000;
      end else if (take_second) begin
         IMMEDIATE_CONSTANT_FIELD <= w;
      end else if (take_first) begin
         IMMEDIATE_CONSTANT_FIELD <= imm_dec;
      end
   end

endmodule : arith_branch_opcode_decoder

/* pkg/opdec_pkg.sv */
// Constants and types for the arithmetic and branch opcode decoder.
// Assumes 16-bit instruction words arriving one per valid strobe.
package opdec_pkg;

   // ==========================================================
   // Word and field layout
   localparam int WORD_W = 16;
   localparam int COND_STATE_LSB = 4;
   localparam int SEL_LSB = 8;
   localparam int BIT_ZERO = 3;
   localparam int BIT_NEG = 2;
   localparam int BIT_OVF = 1;
   localparam int BIT_CARRY = 0;

   // ==========================================================
   // Condition selector codes
   localparam logic [1:0] SEL_PIN_LOW = 2'h0;
   localparam logic [1:0] SEL_FLAG_SET = 2'h1;
   localparam logic [1:0] SEL_FLAG_CLR = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;

   // ==========================================================
   // Opcode patterns
   localparam logic [15:0] PAT_ABS = 16'hbe00;
   localparam logic [15:0] PAT_PRODUCT_ADD_OP = 16'hbe04;
   localparam logic [15:0] PAT_BRANCH_TO_ACC_OP = 16'hbe20;
   localparam logic [15:0] PAT_AND_16 = 16'hbe81;
   localparam logic [11:0] PAT_ADD_IMM_L = 12'hbf9;
   localparam logic [11:0] PAT_AND_IMM_SH = 12'hbfb;
   localparam logic [7:0] PAT_ADD_HIGH = 8'h61;
   localparam logic [7:0] PAT_ADD_IMM_S = 8'hb8;
   localparam logic [7:0] PAT_ADD_CARRY_OP = 8'h60;
   localparam logic [7:0] PAT_ADD_NOSIGNEXT_OP = 8'h62;
   localparam logic [7:0] PAT_ADD_TREG_SHIFT_OP = 8'h63;
   localparam logic [7:0] PAT_AUX_ADD_IMM_OP = 8'h78;
   localparam logic [7:0] PAT_AND_DIR = 8'h6e;
   localparam logic [7:0] PAT_B = 8'h79;
   localparam logic [7:0] PAT_BRANCH_AUX_NONZERO_OP = 8'h7b;
   localparam logic [5:0] PAT_COND_BRANCH_OP = 6'h38;
   localparam logic [3:0] PAT_ADD_SHIFT = 4'h2;

   // ==========================================================
   // Cycle counts
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR = 3'h4;

   // ==========================================================
   // Decoded operations and sequencer states
   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_ABS = 5'h01, OP_ADD_SHIFT = 5'h02, OP_ADD_HIGH = 5'h03,
      OP_ADD_IMM_S = 5'h04, OP_ADD_IMM_L = 5'h05, OP_ADD_CARRY_OP = 5'h06, OP_ADD_NOSIGNEXT_OP = 5'h07,
      OP_ADD_TREG_SHIFT_OP = 5'h08, OP_AUX_ADD_IMM_OP = 5'h09, OP_AND_DIR = 5'h0a, OP_AND_IMM_SH = 5'h0b,
      OP_AND_16 = 5'h0c, OP_PRODUCT_ADD_OP = 5'h0d, OP_B = 5'h0e, OP_BRANCH_TO_ACC_OP = 5'h0f,
      OP_BRANCH_AUX_NONZERO_OP = 5'h10, OP_COND_BRANCH_OP = 5'h11
   } op_t;

   typedef enum logic {
      ST_FIRST = 1'b0,
      ST_SECOND = 1'b1
   } state_t;

endpackage : opdec_pkg

/* testbench/arith_branch_opcode_decoder_chk.sv */
// Checker for the opcode decoder, bound to the top module ports.
// Assumes one word per INSTR_VALID and the one-cycle answer of the decoder.
`timescale 1ns/1ps

module arith_branch_opcode_decoder_chk (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR_WORD,
   input wire logic ACC_ZERO,
   input wire logic ACC_NEG,
   input wire logic OVERFLOW,
   input wire logic CARRY,
   input wire logic TEST_CONTROL_FLAG,
   input wire logic BRANCH_INPUT_PIN,
   input wire logic DECODE_VALID,
   input wire logic [4:0] OP_CODE,
   input wire logic TWO_WORD,
   input wire logic [15:0] IMMEDIATE_CONSTANT_FIELD,
   input wire logic BRANCH_TAKEN,
   input wire logic [2:0] CYCLE_COUNT
);
   // ==========================================================
   // Word tracking
   logic pend;
   wire logic first = INSTR_VALID && !pend;
   wire logic sel_ok = (INSTR_WORD[9:8] == 2'h3) || (INSTR_WORD[7:0] == 8'h00);
   wire logic pair_op = (INSTR_WORD[15:10] == opdec_pkg::PAT_COND_BRANCH_OP && sel_ok) || INSTR_WORD == opdec_pkg::PAT_AND_16
      || INSTR_WORD[15:8] == opdec_pkg::PAT_B || INSTR_WORD[15:8] == opdec_pkg::PAT_BRANCH_AUX_NONZERO_OP
      || INSTR_WORD[15:4] == opdec_pkg::PAT_ADD_IMM_L || INSTR_WORD[15:4] == opdec_pkg::PAT_AND_IMM_SH;
   wire logic [3:0] hit = INSTR_WORD[3:0] & ~(INSTR_WORD[7:4] ^ {ACC_ZERO, ACC_NEG, OVERFLOW, CARRY});
   wire logic acc_br = first && INSTR_WORD[15:8] == 8'he3;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         pend <= 1'b0;
      end else if (INSTR_VALID) begin
         pend <= first && pair_op;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   // ==========================================================
   // Properties
   property p_abs;
      first && INSTR_WORD == opdec_pkg::PAT_ABS |=> DECODE_VALID && OP_CODE == opdec_pkg::OP_ABS && CYCLE_COUNT == 3'h1;
   endproperty
   a_abs: assert property (p_abs) else $error("abs decode wrong");
   property p_product_add_op;
      first && INSTR_WORD == opdec_pkg::PAT_PRODUCT_ADD_OP |=> OP_CODE == opdec_pkg::OP_PRODUCT_ADD_OP && !TWO_WORD && CYCLE_COUNT == 3'h1;
   endproperty
   a_product_add_op: assert property (p_product_add_op) else $error("product add decode wrong");
   property p_branch_to_acc_op;
      first && INSTR_WORD == opdec_pkg::PAT_BRANCH_TO_ACC_OP |=> DECODE_VALID && BRANCH_TAKEN && CYCLE_COUNT == 3'h4;
   endproperty
   a_branch_to_acc_op: assert property (p_branch_to_acc_op) else $error("acc branch decode wrong");
   property p_aux_add_imm_op;
      first && INSTR_WORD[15:8] == 8'h78 |=> OP_CODE == opdec_pkg::OP_AUX_ADD_IMM_OP && IMMEDIATE_CONSTANT_FIELD == {8'h00, $past(INSTR_WORD[7:0])};
   endproperty
   a_aux_add_imm_op: assert property (p_aux_add_imm_op) else $error("aux add decode wrong");
   property p_hold;
      first && pair_op |=> !DECODE_VALID && TWO_WORD;
   endproperty
   a_hold: assert property (p_hold) else $error("pair answered early");
   property p_second;
      pend && INSTR_VALID |=> DECODE_VALID && IMMEDIATE_CONSTANT_FIELD == $past(INSTR_WORD);
   endproperty
   a_second: assert property (p_second) else $error("second word lost");
   property p_taken;
      acc_br && hit != 4'h0 |=> BRANCH_TAKEN && CYCLE_COUNT == 3'h4;
   endproperty
   a_taken: assert property (p_taken) else $error("met condition not taken");
   property p_skip;
      acc_br && hit == 4'h0 |=> !BRANCH_TAKEN && CYCLE_COUNT == 3'h2;
   endproperty
   a_skip: assert property (p_skip) else $error("unmet condition taken");
   property p_flag;
      first && INSTR_WORD == 16'he100 |=> BRANCH_TAKEN == $past(TEST_CONTROL_FLAG);
   endproperty
   a_flag: assert property (p_flag) else $error("flag branch wrong");
   property p_pin;
      first && INSTR_WORD == 16'he000 && BRANCH_INPUT_PIN |=> !BRANCH_TAKEN && CYCLE_COUNT == 3'h3;
   endproperty
   a_pin: assert property (p_pin) else $error("pin branch wrong");
endmodule : arith_branch_opcode_decoder_chk

bind arith_branch_opcode_decoder arith_branch_opcode_decoder_chk chk_inst (.*);

/* testbench/fetch_model.sv */
// Fetch path model: hands one word per call to the decoder.
// Assumes calls start at a falling edge of the clock.
`timescale 1ns/1ps

module fetch_model (
   input wire logic clk,
   output logic valid,
   output logic [15:0] word
);
   initial begin
      valid = 1'b0;
      word = 16'h0000;
   end

   task automatic send(input logic [15:0] w);
      valid = 1'b1;
      word = w;
      @(negedge clk);
   endtask : send

   // A released bus shows the inverse word, so a stale sample cannot pass by luck.
   task automatic idle();
      valid = 1'b0;
      word = ~word;
   endtask : idle
endmodule : fetch_model

/* testbench/tb_arith_branch_opcode_decoder.sv */
// Self-checking bench for the opcode decoder.
// Assumes the fetch model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t got %h exp %h", $time, a, b); end end

module tb_arith_branch_opcode_decoder;
   logic clk, rst_n, zero, neg, ovf, carry, tc, pin, aux, valid, dv, unk, two_w, is_br, taken, cmet;
   logic [7:0] addr;
   logic [15:0] word, imm;
   logic [4:0] op_code;
   logic [3:0] shift;
   logic [2:0] cyc;
   int bad_count = 0;
   int compares = 0;

   fetch_model fetch_model_inst (.clk(clk), .valid(valid), .word(word));
   arith_branch_opcode_decoder arith_branch_opcode_decoder_inst (.SYS_CLK(clk), .RST_N(rst_n),
      .INSTR_VALID(valid), .INSTR_WORD(word), .ACC_ZERO(zero), .ACC_NEG(neg), .OVERFLOW(ovf), .CARRY(carry),
      .TEST_CONTROL_FLAG(tc), .BRANCH_INPUT_PIN(pin), .AUX_NONZERO(aux), .DECODE_VALID(dv), .OP_CODE(op_code),
      .UNKNOWN_OP(unk), .TWO_WORD(two_w), .SHIFT_AMOUNT_FIELD(shift), .DIRECT_INDIRECT_ADDR_FIELD(addr),
      .IMMEDIATE_CONSTANT_FIELD(imm), .IS_BRANCH(is_br), .BRANCH_TAKEN(taken), .COND_MET(cmet), .CYCLE_COUNT(cyc));

   // ==========================================================
   // Shared tasks
   task automatic end_of_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic run(input logic [15:0] w1, input logic [15:0] w2, input logic two, input opdec_pkg::op_t op,
                      input logic [2:0] cy, input logic tk);
      fetch_model_inst.send(w1);
      if (two) begin
         `CHK(dv, 1'b0)
         fetch_model_inst.idle();
         @(negedge clk);
         fetch_model_inst.send(w2);
         `CHK(imm, w2)
      end
      fetch_model_inst.idle();
      `CHK(dv, 1'b1)
      `CHK(op_code, op)
      `CHK(unk, op == opdec_pkg::OP_NONE)
      `CHK(two_w, two)
      `CHK(is_br, op >= opdec_pkg::OP_B)
      `CHK(cyc, cy)
      `CHK(taken, tk)
      `CHK(addr, w1[7:0])
      @(negedge clk);
   endtask : run

   // ==========================================================
   // Scenarios
   task automatic t_single;
      logic [15:0] w[12] = '{16'hbe00, 16'hbe04, 16'hbe20, 16'h2a35, 16'h6155, 16'hb8c3, 16'h6011, 16'h6222,
                             16'h6333, 16'h7844, 16'h6e66, 16'hffff};
      opdec_pkg::op_t op[12] = '{opdec_pkg::OP_ABS, opdec_pkg::OP_PRODUCT_ADD_OP, opdec_pkg::OP_BRANCH_TO_ACC_OP, opdec_pkg::OP_ADD_SHIFT,
         opdec_pkg::OP_ADD_HIGH, opdec_pkg::OP_ADD_IMM_S, opdec_pkg::OP_ADD_CARRY_OP, opdec_pkg::OP_ADD_NOSIGNEXT_OP, opdec_pkg::OP_ADD_TREG_SHIFT_OP,
         opdec_pkg::OP_AUX_ADD_IMM_OP, opdec_pkg::OP_AND_DIR, opdec_pkg::OP_NONE};
      for (int i = 0; i < 12; i++) begin
         run(w[i], 16'h0000, 1'b0, op[i], (i == 2) ? 3'h4 : 3'h1, i == 2);
         if (i == 3) `CHK(shift, 4'ha)
         if (i == 5) `CHK(imm, 16'h00c3)
      end
   endtask : t_single

   task automatic t_pairs;
      run(16'hbf95, 16'h1234, 1'b1, opdec_pkg::OP_ADD_IMM_L, 3'h2, 1'b0);
      `CHK(shift, 4'h5)
      run(16'hbfb3, 16'habcd, 1'b1, opdec_pkg::OP_AND_IMM_SH, 3'h2, 1'b0);
      run(16'hbe81, 16'h5a5a, 1'b1, opdec_pkg::OP_AND_16, 3'h2, 1'b0);
      run(16'h7955, 16'h0600, 1'b1, opdec_pkg::OP_B, 3'h4, 1'b1);
      run(16'he105, 16'h0000, 1'b0, opdec_pkg::OP_NONE, 3'h1, 1'b0);
   endtask : t_pairs

   task automatic t_cond;
      logic [7:0] lo[7] = '{8'h8c, 8'h04, 8'hcc, 8'h44, 8'h11, 8'h01, 8'h02};
      logic t;
      for (int i = 0; i < 7; i++) begin
         for (int j = 0; j < 16; j++) begin
            {zero, neg, ovf, carry} = 4'(j);
            t = |(lo[i][3:0] & ~(lo[i][7:4] ^ 4'(j)));
            run({8'he3, lo[i]}, 16'h0100 + 16'(j), 1'b1, opdec_pkg::OP_COND_BRANCH_OP, t ? 3'h4 : 3'h2, t);
            `CHK(cmet, t)
         end
      end
   endtask : t_cond

   task automatic t_sel;
      for (int j = 0; j < 2; j++) begin
         {tc, pin, aux} = {3{j[0]}};
         run(16'he100, 16'h0200, 1'b1, opdec_pkg::OP_COND_BRANCH_OP, tc ? 3'h4 : 3'h2, tc);
         `CHK(cmet, tc)
         run(16'he200, 16'h0300, 1'b1, opdec_pkg::OP_COND_BRANCH_OP, tc ? 3'h2 : 3'h4, !tc);
         `CHK(cmet, !tc)
         run(16'he000, 16'h0400, 1'b1, opdec_pkg::OP_COND_BRANCH_OP, pin ? 3'h3 : 3'h4, !pin);
         `CHK(cmet, !pin)
         run(16'h7b85, 16'h0500, 1'b1, opdec_pkg::OP_BRANCH_AUX_NONZERO_OP, aux ? 3'h4 : 3'h2, aux);
      end
   endtask : t_sel

   // A reset between the two words must drop the half-taken pair.
   task automatic t_reset;
      fetch_model_inst.send(16'hbf95);
      fetch_model_inst.idle();
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      `CHK(dv, 1'b0)
      run(16'hbe00, 16'h0000, 1'b0, opdec_pkg::OP_ABS, 3'h1, 1'b0);
   endtask : t_reset

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_of_test();
   end

   initial begin
      {rst_n, zero, neg, ovf, carry, tc, pin, aux} = 8'h00;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_single();
      t_pairs();
      t_cond();
      t_sel();
      t_reset();
      end_of_test();
   end
endmodule : tb_arith_branch_opcode_decoder
